//--- bert_defs.svh
// Purpose: Offsets, field positions, reset values and pattern constants
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes:   Included by the package and by the design modules
`ifndef BERT_DEFS_SVH
`define BERT_DEFS_SVH

// Register map
`define AXI_ADDR_W        8
`define OFS_PATTERN_CTRL  8'h00
`define OFS_PATTERN_STAT  8'h04

// Control register fields and reset
`define FLD_PATTERN_TYPE  7
`define FLD_ERROR_INJECT  6
`define FLD_DATA_INVERT   5
`define CTRL_WR_MASK      8'he0
`define RST_PATTERN_CTRL  8'h00

// Status register fields
`define FLD_INJ_PENDING   0
`define FLD_TX_GEN_ACTIVE 1
`define FLD_RX_GEN_ACTIVE 2
`define FLD_SWITCH        3

// Bus responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

// Polynomial generator x^15 + x^14 + 1
`define PRBS_LEN          15
`define PRBS_SEED         15'h7fff

// Quasi-random generator x^20 + x^17 + 1 with zero-run limit
`define QUASI_RANDOM_PATTERN_LEN          20
`define QUASI_RANDOM_PATTERN_TAP          17
`define QUASI_RANDOM_PATTERN_ZERO_RUN     14
`define QUASI_RANDOM_PATTERN_SEED         20'hfffff

`endif

//--- bert_pkg.sv
// Purpose: Shared types for the test pattern control block
// Assumes: bert_defs.svh holds all numeric constants
// Notes:   Bus FSM states are Gray coded along idle-take-respond
`include "bert_defs.svh"

package bert_pkg;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_TAKE = 2'b01,
      ST_RESP = 2'b11
   } bus_state_t;

   typedef enum logic [1:0]
   {
      SEL_CTRL = 2'b00,
      SEL_STAT = 2'b01,
      SEL_NONE = 2'b10
   } reg_sel_t;

   function automatic reg_sel_t decode_reg(input logic [`AXI_ADDR_W-1:0] addr);
      logic [`AXI_ADDR_W-1:0] word;
      word = {addr[`AXI_ADDR_W-1:2], 2'b00};
      if (word == `OFS_PATTERN_CTRL)
         return SEL_CTRL;
      else if (word == `OFS_PATTERN_STAT)
         return SEL_STAT;
      else
         return SEL_NONE;
   endfunction : decode_reg

endpackage : bert_pkg

//--- pattern_if.sv
// Purpose: Carries generator and injection signals inside the block
// Assumes: One bit time per step pulse
// Notes:   ctl side is the top, gen and inj are the leaf modules
`timescale 1ns/1ps

interface pattern_if;
   logic step;
   logic gen_en;
   logic sel_quasi_random_pattern;
   logic inject_ctl;
   logic raw_bit;
   logic flip;
   logic pending;

   modport ctl (output step, gen_en, sel_quasi_random_pattern, inject_ctl, input raw_bit, flip, pending);
   modport gen (input step, sel_quasi_random_pattern, output raw_bit);
   modport inj (input step, gen_en, inject_ctl, output flip, pending);
endinterface : pattern_if

//--- pattern_gen.sv
// Purpose: Polynomial and quasi-random test sequence generator
// Assumes: Advances one bit per step pulse
// Notes:   Both registers run together; selection picks the output
`timescale 1ns/1ps
`include "bert_defs.svh"

module pattern_gen
   import bert_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // Generator side
   pattern_if.gen   pif
);

   logic [`PRBS_LEN-1:0] prbs_ff;
   logic [`QUASI_RANDOM_PATTERN_LEN-1:0] quasi_random_pattern_ff;
   logic [`PRBS_LEN-1:0] nxt_prbs;
   logic [`QUASI_RANDOM_PATTERN_LEN-1:0] nxt_quasi_random_pattern;
   logic                 prbs_bit;
   logic                 quasi_random_pattern_bit;
   logic                 quasi_random_pattern_zero_run;

   assign prbs_bit      = prbs_ff[`PRBS_LEN-1];
   assign nxt_prbs      = {prbs_ff[`PRBS_LEN-2:0], prbs_ff[`PRBS_LEN-1] ^ prbs_ff[`PRBS_LEN-2]};
   assign nxt_quasi_random_pattern      = {quasi_random_pattern_ff[`QUASI_RANDOM_PATTERN_LEN-2:0],
                           quasi_random_pattern_ff[`QUASI_RANDOM_PATTERN_LEN-1] ^ quasi_random_pattern_ff[`QUASI_RANDOM_PATTERN_TAP-1]};
   // Long zero runs are forced to one
   assign quasi_random_pattern_zero_run = (quasi_random_pattern_ff[`QUASI_RANDOM_PATTERN_LEN-1 -: `QUASI_RANDOM_PATTERN_ZERO_RUN] == '0);
   assign quasi_random_pattern_bit      = quasi_random_pattern_ff[`QUASI_RANDOM_PATTERN_LEN-1] | quasi_random_pattern_zero_run;

   assign pif.raw_bit   = pif.sel_quasi_random_pattern ? quasi_random_pattern_bit : prbs_bit;

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         prbs_ff <= `PRBS_SEED;
         quasi_random_pattern_ff <= `QUASI_RANDOM_PATTERN_SEED;
      end
      else if (ce_i && pif.step)
      begin
         prbs_ff <= nxt_prbs;
         quasi_random_pattern_ff <= nxt_quasi_random_pattern;
      end
   end

   // Output history for the recurrence check
   logic [14:0] hist_ff;
   logic [3:0]  seen_ff;

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         hist_ff <= '0;
         seen_ff <= '0;
      end
      else if (ce_i && pif.step)
      begin
         hist_ff <= {hist_ff[13:0], prbs_bit};
         seen_ff <= (seen_ff == 4'hf) ? seen_ff : seen_ff + 4'h1;
      end
   end

   property p_prbs_recurrence;
      @(posedge clk_i) disable iff (reset_i)
      (ce_i && pif.step && !pif.sel_quasi_random_pattern && seen_ff == 4'hf)
         |-> (pif.raw_bit == (hist_ff[14] ^ hist_ff[13]));
   endproperty
   a_prbs_recurrence: assert property (p_prbs_recurrence)
      else $error("Polynomial output breaks x^15+x^14+1 recurrence");

endmodule : pattern_gen

//--- error_inject.sv
// Purpose: Turns a rising inject control into one flipped test bit
// Assumes: Step pulses only while generation is enabled
// Notes:   A new rising edge wins over the consuming step
`timescale 1ns/1ps
`include "bert_defs.svh"

module error_inject
   import bert_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // Injection side
   pattern_if.inj   pif
);

   logic prev_ff;
   logic pending_ff;
   logic rise;
   logic nxt_pending;

   assign rise        = pif.inject_ctl & ~prev_ff;
   // requests dropped while generator is off
   assign nxt_pending = pif.gen_en & (rise | (pending_ff & ~pif.step));
   assign pif.flip    = pending_ff;
   assign pif.pending = pending_ff;

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         prev_ff    <= 1'b0;
         pending_ff <= 1'b0;
      end
      else if (ce_i)
      begin
         prev_ff    <= pif.inject_ctl;
         pending_ff <= nxt_pending;
      end
   end

   property p_inject_once;
      @(posedge clk_i) disable iff (reset_i)
      (ce_i && pif.step && pending_ff && !rise) |=> !pending_ff;
   endproperty
   a_inject_once: assert property (p_inject_once)
      else $error("Injected error was not consumed after one bit");

   property p_inject_gated;
      @(posedge clk_i) disable iff (reset_i)
      (ce_i && !pif.gen_en) |=> !pending_ff;
   endproperty
   a_inject_gated: assert property (p_inject_gated)
      else $error("Injection pending while generator disabled");

   property p_inject_hold;
      @(posedge clk_i) disable iff (reset_i)
      (ce_i && pif.gen_en && pif.inject_ctl && prev_ff && !pending_ff) |=> !pending_ff;
   endproperty
   a_inject_hold: assert property (p_inject_hold)
      else $error("Held inject control produced another error");

endmodule : error_inject

//--- bert_pattern_control.sv
// Purpose: Test pattern selection, error injection, inversion, routing
// Assumes: bit_strobe_i marks one bit time of the framer data path
// Notes:   Switch and generation enable arrive as control inputs
`timescale 1ns/1ps
`include "bert_defs.svh"

module bert_pattern_control
   import bert_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                   clk_i,
   input  wire logic                   reset_i,
   input  wire logic                   ce_i,
   // AXI4-Lite write address and data
   input  wire logic [`AXI_ADDR_W-1:0] awaddr_i,
   input  wire logic                   awvalid_i,
   output logic                        awready_o,
   input  wire logic [31:0]            wdata_i,
   input  wire logic [3:0]             wstrb_i,
   input  wire logic                   wvalid_i,
   output logic                        wready_o,
   // AXI4-Lite write response
   output logic [1:0]                  bresp_o,
   output logic                        bvalid_o,
   input  wire logic                   bready_i,
   // AXI4-Lite read
   input  wire logic [`AXI_ADDR_W-1:0] araddr_i,
   input  wire logic                   arvalid_i,
   output logic                        arready_o,
   output logic [31:0]                 rdata_o,
   output logic [1:0]                  rresp_o,
   output logic                        rvalid_o,
   input  wire logic                   rready_i,
   // Control inputs
   input  wire logic                   bert_switch_i,
   input  wire logic                   tx_pattern_gen_enable_i,
   input  wire logic                   bit_strobe_i,
   // Framer data inputs
   input  wire logic                   tx_data_i,
   input  wire logic                   rx_data_i,
   input  wire logic                   line_rx_data_i,
   input  wire logic                   tx_backplane_data_i,
   // Data outputs
   output logic                        line_data_o,
   output logic                        rx_backplane_data_o,
   output logic                        rx_check_data_o,
   output logic                        tx_check_data_o
);

   pattern_if pif ();

   pattern_gen pattern_gen_inst
   (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .ce_i    (ce_i),
      .pif     (pif.gen)
   );

   error_inject error_inject_inst
   (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .ce_i    (ce_i),
      .pif     (pif.inj)
   );

   // Register state
   logic [7:0]  ctrl_ff;
   logic [7:0]  nxt_ctrl;
   bus_state_t  wr_st_ff;
   bus_state_t  nxt_wr_st;
   bus_state_t  rd_st_ff;
   bus_state_t  nxt_rd_st;
   logic [1:0]  bresp_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic        aw_rdy_ff;
   logic        ar_rdy_ff;

   // Data path state
   logic        line_ff;
   logic        rx_bp_ff;
   logic        rx_chk_ff;
   logic        tx_chk_ff;

   // Decoded controls
   logic        sel_quasi_random_pattern;
   logic        inject_ctl;
   logic        invert;
   logic        bit_time;
   logic        tx_gen_active;
   logic        rx_gen_active;
   logic        gen_bit;
   logic        nxt_line;
   logic        nxt_rx_bp;
   logic        nxt_rx_chk;
   logic        nxt_tx_chk;

   assign sel_quasi_random_pattern   = ctrl_ff[`FLD_PATTERN_TYPE];
   assign inject_ctl = ctrl_ff[`FLD_ERROR_INJECT];
   assign invert     = ctrl_ff[`FLD_DATA_INVERT];
   assign bit_time   = ce_i & bit_strobe_i;

   assign pif.sel_quasi_random_pattern   = sel_quasi_random_pattern;
   assign pif.inject_ctl = inject_ctl;
   assign pif.gen_en     = tx_pattern_gen_enable_i;
   assign pif.step       = bit_strobe_i & tx_pattern_gen_enable_i;

   assign tx_gen_active = tx_pattern_gen_enable_i & ~bert_switch_i;
   assign rx_gen_active = tx_pattern_gen_enable_i & bert_switch_i;

   // flip and invert on the generated bit
   assign gen_bit    = pif.raw_bit ^ pif.flip ^ invert;
   assign nxt_line   = tx_gen_active ? gen_bit : tx_data_i;
   assign nxt_rx_bp  = rx_gen_active ? gen_bit : rx_data_i;
   // receive checker inverts with switch off
   assign nxt_rx_chk = line_rx_data_i ^ (invert & ~bert_switch_i);
   // transmit checker inverts with switch on
   assign nxt_tx_chk = tx_backplane_data_i ^ (invert & bert_switch_i);

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         line_ff   <= 1'b0;
         rx_bp_ff  <= 1'b0;
         rx_chk_ff <= 1'b0;
         tx_chk_ff <= 1'b0;
      end
      else if (bit_time)
      begin
         line_ff   <= nxt_line;
         rx_bp_ff  <= nxt_rx_bp;
         rx_chk_ff <= nxt_rx_chk;
         tx_chk_ff <= nxt_tx_chk;
      end
   end

   // Bus decode
   reg_sel_t wr_sel;
   reg_sel_t rd_sel;
   logic     wr_take;
   logic     rd_take;
   logic     ctrl_wr;
   logic [31:0] stat_word;
   logic [31:0] rd_word;

   assign wr_sel  = decode_reg(awaddr_i);
   assign rd_sel  = decode_reg(araddr_i);
   assign wr_take = (wr_st_ff == ST_TAKE);
   assign rd_take = (rd_st_ff == ST_TAKE);
   assign ctrl_wr = wr_take & (wr_sel == SEL_CTRL) & wstrb_i[0];
   assign nxt_ctrl = ctrl_wr ? (wdata_i[7:0] & `CTRL_WR_MASK) : ctrl_ff;

   assign stat_word = {28'h0000000, bert_switch_i, rx_gen_active, tx_gen_active, pif.pending};
   assign rd_word   = (rd_sel == SEL_CTRL) ? {24'h000000, ctrl_ff} :
                      (rd_sel == SEL_STAT) ? stat_word : 32'h00000000;

   always_comb
   begin
      case (wr_st_ff)
         ST_IDLE: nxt_wr_st = (awvalid_i && wvalid_i) ? ST_TAKE : ST_IDLE;
         ST_TAKE: nxt_wr_st = ST_RESP;
         ST_RESP: nxt_wr_st = bready_i ? ST_IDLE : ST_RESP;
         default: nxt_wr_st = ST_IDLE;
      endcase
   end

   always_comb
   begin
      case (rd_st_ff)
         ST_IDLE: nxt_rd_st = arvalid_i ? ST_TAKE : ST_IDLE;
         ST_TAKE: nxt_rd_st = ST_RESP;
         ST_RESP: nxt_rd_st = rready_i ? ST_IDLE : ST_RESP;
         default: nxt_rd_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         ctrl_ff <= `RST_PATTERN_CTRL;
      else if (ce_i)
         ctrl_ff <= nxt_ctrl;
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         wr_st_ff  <= ST_IDLE;
         aw_rdy_ff <= 1'b0;
         bresp_ff  <= `RESP_OKAY;
      end
      else if (ce_i)
      begin
         wr_st_ff  <= nxt_wr_st;
         aw_rdy_ff <= (nxt_wr_st == ST_TAKE);
         if (wr_take)
            bresp_ff <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         rd_st_ff <= ST_IDLE;
         ar_rdy_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= `RESP_OKAY;
      end
      else if (ce_i)
      begin
         rd_st_ff <= nxt_rd_st;
         ar_rdy_ff <= (nxt_rd_st == ST_TAKE);
         if (rd_take)
         begin
            rdata_ff <= rd_word;
            rresp_ff <= (rd_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
         end
      end
   end

   // Outputs straight from flip-flops
   assign awready_o           = aw_rdy_ff;
   assign wready_o            = aw_rdy_ff;
   assign bvalid_o            = wr_st_ff[1];
   assign bresp_o             = bresp_ff;
   assign arready_o           = ar_rdy_ff;
   assign rvalid_o            = rd_st_ff[1];
   assign rdata_o             = rdata_ff;
   assign rresp_o             = rresp_ff;
   assign line_data_o         = line_ff;
   assign rx_backplane_data_o = rx_bp_ff;
   assign rx_check_data_o     = rx_chk_ff;
   assign tx_check_data_o     = tx_chk_ff;

   property p_tx_route;
      @(posedge clk_i) disable iff (reset_i)
      (bit_time && tx_pattern_gen_enable_i && !bert_switch_i) |=> (line_data_o == $past(gen_bit));
   endproperty
   a_tx_route: assert property (p_tx_route)
      else $error("Line output is not the generated pattern");

   property p_rx_route;
      @(posedge clk_i) disable iff (reset_i)
      (bit_time && tx_pattern_gen_enable_i && bert_switch_i)
         |=> (rx_backplane_data_o == $past(gen_bit)) && (line_data_o == $past(tx_data_i));
   endproperty
   a_rx_route: assert property (p_rx_route)
      else $error("Backplane output is not the generated pattern");

   property p_error_seen;
      @(posedge clk_i) disable iff (reset_i)
      (bit_time && pif.step && pif.flip)
         |=> ((bert_switch_i ? rx_backplane_data_o : line_data_o) != $past(pif.raw_bit ^ invert));
   endproperty
   a_error_seen: assert property (p_error_seen)
      else $error("Injected error missing from selected output");

   property p_invert_off_switch;
      @(posedge clk_i) disable iff (reset_i)
      (bit_time && invert && !bert_switch_i) |=> (rx_check_data_o != $past(line_rx_data_i));
   endproperty
   a_invert_off_switch: assert property (p_invert_off_switch)
      else $error("Receive check data not inverted");

   property p_invert_on_switch;
      @(posedge clk_i) disable iff (reset_i)
      (bit_time && invert && bert_switch_i) |=> (tx_check_data_o != $past(tx_backplane_data_i));
   endproperty
   a_invert_on_switch: assert property (p_invert_on_switch)
      else $error("Transmit check data not inverted");

   property p_no_invert;
      @(posedge clk_i) disable iff (reset_i)
      (bit_time && !invert && !pif.flip)
         |=> (rx_check_data_o == $past(line_rx_data_i))
             && (tx_check_data_o == $past(tx_backplane_data_i))
             && (!$past(tx_gen_active) || line_data_o == $past(pif.raw_bit));
   endproperty
   a_no_invert: assert property (p_no_invert)
      else $error("Data inverted while invert control clear");

   property p_gen_disabled;
      @(posedge clk_i) disable iff (reset_i)
      (bit_time && !tx_pattern_gen_enable_i)
         |=> (line_data_o == $past(tx_data_i)) && (rx_backplane_data_o == $past(rx_data_i));
   endproperty
   a_gen_disabled: assert property (p_gen_disabled)
      else $error("Pattern present while generation disabled");

   property p_reset_ctrl;
      @(posedge clk_i)
      reset_i |=> (ctrl_ff == `RST_PATTERN_CTRL) && !pif.pending;
   endproperty
   a_reset_ctrl: assert property (p_reset_ctrl)
      else $error("Controls not cleared by reset");

endmodule : bert_pattern_control

//--- framer_path_model.sv
// Purpose: Far-side data path model feeding framer data and bit strobes
// Assumes: Data lines take a new LFSR bit every cycle, so stale values match only by chance
// Notes:   slow_i spaces the bit strobes three cycles apart
`timescale 1ns/1ps

module framer_path_model
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic slow_i,
   // Toward the block
   output logic      bit_strobe_o,
   output logic      tx_data_o,
   output logic      rx_data_o,
   output logic      line_rx_data_o,
   output logic      tx_backplane_data_o
);
   logic [8:0] lfsr_ff = 9'h1ff;
   logic [1:0] gap_ff;

   assign bit_strobe_o        = ~reset_i & (~slow_i | (gap_ff == 2'h0));
   assign tx_data_o           = lfsr_ff[0];
   assign rx_data_o           = lfsr_ff[3];
   assign line_rx_data_o      = lfsr_ff[5];
   assign tx_backplane_data_o = lfsr_ff[7];

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         gap_ff <= 2'h0;
      else
         gap_ff <= (gap_ff == 2'h2) ? 2'h0 : gap_ff + 2'h1;
   end

   // Data keeps changing, also in reset
   always_ff @(posedge clk_i)
   begin
      lfsr_ff <= (lfsr_ff == 9'h0) ? 9'h1ff : {lfsr_ff[7:0], lfsr_ff[8] ^ lfsr_ff[4]};
   end
endmodule : framer_path_model

//--- tb_bert_pattern_control.sv
// Purpose: Self-checking bench for the test pattern control block
// Assumes: Register offsets and responses from bert_defs.svh
// Notes:   Pattern streams are judged by their recurrence, not a copy
`timescale 1ns/1ps
`include "bert_defs.svh"

module tb_bert_pattern_control
   import bert_pkg::*;
;
   logic        clk_i     = 1'b0;
   logic        reset_i   = 1'b1;
   logic [7:0]  awaddr_i  = 8'h00;
   logic [7:0]  araddr_i  = 8'h00;
   logic [31:0] wdata_i   = 32'h0;
   logic        awvalid_i = 1'b0;
   logic        wvalid_i  = 1'b0;
   logic        bready_i  = 1'b0;
   logic        arvalid_i = 1'b0;
   logic        rready_i  = 1'b0;
   logic        sw_i      = 1'b0;
   logic        gen_i     = 1'b0;
   logic        slow_i    = 1'b0;
   logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
   logic [1:0]  bresp_o, rresp_o;
   logic [31:0] rdata_o;
   logic        strobe, txd, rxd, lrxd, tbpd;
   logic        line_o, rxbp_o, rxchk_o, txchk_o;
   logic        strb_d = 1'b0;
   logic        tx_d, rx_d, lrx_d, tbp_d;
   logic        chk_on = 1'b0;
   logic        cap_on = 1'b0;
   logic        inv_s  = 1'b0;
   logic        sw_s   = 1'b0;
   logic        gen_s  = 1'b0;
   logic        capq[$];
   int          error_cnt = 0;
   int          n_checks  = 0;

   always #20 clk_i = ~clk_i;

   bert_pattern_control bert_pattern_control_inst (.clk_i(clk_i), .reset_i(reset_i),
      .ce_i(1'b1), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
      .wdata_i(wdata_i), .wstrb_i(4'hf), .wvalid_i(wvalid_i), .wready_o(wready_o),
      .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i), .araddr_i(araddr_i),
      .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
      .rvalid_o(rvalid_o), .rready_i(rready_i), .bert_switch_i(sw_i),
      .tx_pattern_gen_enable_i(gen_i), .bit_strobe_i(strobe), .tx_data_i(txd),
      .rx_data_i(rxd), .line_rx_data_i(lrxd), .tx_backplane_data_i(tbpd),
      .line_data_o(line_o), .rx_backplane_data_o(rxbp_o), .rx_check_data_o(rxchk_o),
      .tx_check_data_o(txchk_o));

   framer_path_model framer_path_model_inst (.clk_i(clk_i), .reset_i(reset_i),
      .slow_i(slow_i), .bit_strobe_o(strobe), .tx_data_o(txd), .rx_data_o(rxd),
      .line_rx_data_o(lrxd), .tx_backplane_data_o(tbpd));

   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t ns: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : cmp

   task automatic hang;
      error_cnt++;
      $display("wrong value at %0t ns: no answer", $time);
      end_sim();
   endtask : hang

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge clk_i);
      awaddr_i  <= a;
      awvalid_i <= 1'b1;
      wdata_i   <= d;
      wvalid_i  <= 1'b1;
      bready_i  <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clk_i);
         if (awready_o === 1'b1)
            awvalid_i <= 1'b0;
         if (wready_o === 1'b1)
            wvalid_i <= 1'b0;
         if (bvalid_o === 1'b1)
            break;
      end
      bready_i <= 1'b0;
      if (i == 50)
         hang();
      cmp(bresp_o, er, "write response");
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int i;
      @(posedge clk_i);
      araddr_i  <= a;
      arvalid_i <= 1'b1;
      rready_i  <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clk_i);
         if (arready_o === 1'b1)
            arvalid_i <= 1'b0;
         if (rvalid_o === 1'b1)
            break;
      end
      rready_i <= 1'b0;
      if (i == 50)
         hang();
      cmp(rdata_o, ed, "read data");
      cmp(rresp_o, er, "read response");
   endtask : axi_read

   // Bit level pass-through and checker paths, one look per bit time
   always @(posedge clk_i)
   begin
      if (strb_d && chk_on)
      begin
         if (!(gen_s && !sw_s))
            cmp(line_o, tx_d, "line pass");
         if (!(gen_s && sw_s))
            cmp(rxbp_o, rx_d, "backplane pass");
         cmp(rxchk_o, lrx_d ^ (inv_s & ~sw_s), "rx check data");
         cmp(txchk_o, tbp_d ^ (inv_s & sw_s), "tx check data");
         if (cap_on)
            capq.push_back(sw_s ? rxbp_o : line_o);
      end
      strb_d <= strobe & ~reset_i;
      if (strobe)
      begin
         tx_d  <= txd;
         rx_d  <= rxd;
         lrx_d <= lrxd;
         tbp_d <= tbpd;
      end
   end

   // Count breaks of out(n) = out(n-15) ^ out(n-14), inverted when asked
   function automatic int viol(input logic inv);
      int v = 0;
      for (int i = 15; i < capq.size(); i++)
         if ((capq[i] ^ capq[i-14] ^ capq[i-15]) !== inv)
            v++;
      return v;
   endfunction : viol

   task automatic grab(input int n);
      int k;
      for (k = 0; k < 500 && capq.size() < n; k++)
         @(posedge clk_i);
      if (k == 500)
         hang();
   endtask : grab

   task automatic cfg(input logic s, input logic g, input logic [7:0] c, input logic sl);
      chk_on <= 1'b0;
      axi_write(`OFS_PATTERN_CTRL, {24'h0, c}, `RESP_OKAY);
      sw_i   <= s;
      gen_i  <= g;
      slow_i <= sl;
      repeat (4) @(posedge clk_i);
      inv_s  <= c[`FLD_DATA_INVERT];
      sw_s   <= s;
      gen_s  <= g;
      chk_on <= 1'b1;
      axi_read(`OFS_PATTERN_STAT, {28'h0, s, s & g, ~s & g, 1'b0}, `RESP_OKAY);
   endtask : cfg

   task automatic run_bits(input int n);
      capq.delete();
      cap_on <= 1'b1;
      grab(n);
      cap_on <= 1'b0;
   endtask : run_bits

   initial
   begin
      repeat (50000) @(posedge clk_i);
      hang();
   end

   initial
   begin
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      axi_read(`OFS_PATTERN_CTRL, 32'h0, `RESP_OKAY);
      axi_read(8'h08, 32'h0, `RESP_SLVERR);
      axi_write(8'h08, 32'hff, `RESP_SLVERR);
      axi_write(`OFS_PATTERN_STAT, 32'hff, `RESP_OKAY);
      axi_write(`OFS_PATTERN_CTRL, 32'hff, `RESP_OKAY);
      axi_read(`OFS_PATTERN_CTRL, 32'he0, `RESP_OKAY);
      for (int m = 0; m < 4; m++)
      begin
         cfg(m[0], 1'b1, {2'b00, m[1], 5'h00}, m[1]);
         run_bits(60);
         cmp(viol(m[1]), 32'h0, "polynomial stream");
      end
      cfg(1'b0, 1'b1, 8'h80, 1'b0);
      run_bits(60);
      cmp({31'h0, viol(1'b0) == 0}, 32'h0, "quasi-random stream");
      for (int s = 0; s < 2; s++)
      begin
         cfg(s[0], 1'b1, 8'h00, 1'b0);
         capq.delete();
         cap_on <= 1'b1;
         grab(30);
         axi_write(`OFS_PATTERN_CTRL, 32'h40, `RESP_OKAY);
         grab(120);
         cap_on <= 1'b0;
         cmp(viol(1'b0), 32'h3, "single error");
      end
      cfg(1'b0, 1'b0, 8'h00, 1'b0);
      axi_write(`OFS_PATTERN_CTRL, 32'h40, `RESP_OKAY);
      axi_read(`OFS_PATTERN_STAT, 32'h0, `RESP_OKAY);
      run_bits(30);
      cfg(1'b0, 1'b1, 8'h40, 1'b0);
      run_bits(60);
      cmp(viol(1'b0), 32'h0, "no error when disabled");
      chk_on <= 1'b0;
      axi_write(`OFS_PATTERN_CTRL, 32'he0, `RESP_OKAY);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      axi_read(`OFS_PATTERN_CTRL, 32'h0, `RESP_OKAY);
      end_sim();
   end
endmodule : tb_bert_pattern_control
